/* File: rlbpc_pkg.sv */
// Purpose: Shared constants for the LED brightness and segmented PWM core
// Assumes: 10 MHz core clock, 218-bit control latch layout below
// Notes:   Latch offsets and field widths, the output-off reset value and the latch quiet time live here
package rlbpc_pkg;

    // Core clock
    localparam int CLK_PERIOD_NS = 100;

    // Serial link and latch widths
    localparam int SHIFT_W = 224;
    localparam int LATCH_W = 218;

    // Function bits of the control latch
    localparam int BIT_EDGE_SEL  = 217;
    localparam int BIT_EXT_CLOCK = 216;
    localparam int BIT_BLANK     = 213;
    localparam logic BLANK_RESET = 1'b1;

    // Current scale fields, one per color group
    localparam int BC_W       = 7;
    localparam int BC_LSB_RED = 192;
    localparam int BC_LSB_GRN = 199;
    localparam int BC_LSB_BLU = 206;

    // Grayscale fields: channel i at bits 16*i+15 : 16*i
    localparam int N_CH = 12;
    localparam int GS_W = 16;
    localparam logic [15:0] GS_ZERO = 16'h0000;
    localparam logic [15:0] GS_MAX  = 16'hFFFF;

    // Segment layout of the counter: 128 segments of 512 counts
    localparam int SEG_W = 7;
    localparam int POS_W = 9;

    // Quiet time after the last shift clock rising edge before the latch loads
    localparam int LATCH_IDLE_NS  = 8000;
    localparam int LATCH_IDLE_CYC = (LATCH_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W     = 8;

    // Latch sequencer states, Gray coded except LOAD back to IDLE, which changes both bits
    typedef enum logic [1:0] {
        RLBPC_L_IDLE  = 2'b00,
        RLBPC_L_SHIFT = 2'b01,
        RLBPC_L_LOAD  = 2'b11
    } rlbpc_lstate_t;

endpackage

/* File: rlbpc_pwm_if.sv */
// Purpose: Carrier between the core and its segmented PWM comparator
// Assumes: rlbpc_pkg compiled first
// Notes:   Comparator is purely combinational
`timescale 1ns/10ps
`default_nettype none
interface rlbpc_pwm_if;
    logic [15:0]             cnt;
    logic [11:0][15:0]       gs;
    logic [11:0]             on;

    modport core (output cnt, output gs, input on);
    modport pwm  (input cnt, input gs, output on);
endinterface
`default_nettype wire

/* File: rlbpc_espwm.sv */
// Purpose: Segmented PWM decision for all twelve channels
// Assumes: Counter splits into segment index (top 7) and position (low 9)
// Notes:   Remainder counts are spread over segments in bit-reversed order
`timescale 1ns/10ps
`default_nettype none
module rlbpc_espwm (
    // Counter and grayscale in, on flags out
    rlbpc_pwm_if.pwm p
);
    import rlbpc_pkg::*;

    // Bit reversal gives the 0,64,32,96,16... segment spreading order
    function automatic logic [6:0] rlbpc_rev7(input logic [6:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < SEG_W; i++) begin
            r[i] = v[SEG_W-1-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-channel on decision
    always_comb begin
        logic [6:0] seg;
        logic [8:0] pos;
        logic [9:0] thr;
        logic       extra;
        seg   = p.cnt[15:9];
        pos   = p.cnt[8:0];
        thr   = 10'h000;
        extra = 1'b0;
        for (int ch = 0; ch < N_CH; ch++) begin
            extra = (rlbpc_rev7(seg) < p.gs[ch][6:0]);
            thr   = {1'b0, p.gs[ch][15:7]} + {9'h000, extra};
            p.on[ch] = (p.gs[ch] == GS_MAX) || ({1'b0, pos} < thr);
        end
    end

endmodule
`default_nettype wire

/* File: rlbpc_core.sv */
// Purpose: Brightness core: serial shift, control latch, counter, PWM outputs
// Assumes: Shift clock and data arrive asynchronously and are synchronised
// Notes:   Latch loads after a quiet period on the shift clock
//
// What this block does
// - Hold a 7-bit current scale per color group, 128 steps from 0 to full.
// - One scale value applies to all four outputs of its color group.
// - A newly latched scale reaches the current outputs at once.
// - Group sink current equals max channel current times scale over 127.
// - At reset only the output-off flag of the latch initialises, to one.
// - Shift register and other latch bits stay undefined after reset.
// - Each of twelve outputs has its own 16-bit grayscale value.
// - One shared 16-bit counter drives PWM of all groups.
// - Latch bit 217 picks counting edge, bit 216 picks clock source.
// - External source uses the serial shift clock as reference.
// - Output-off set clears the counter and forces outputs off.
// - Counter stays zero while output-off is set, whatever clocks arrive.
// - On-time equals grayscale value times one reference clock period; 16'hFFFF stays on for the whole period.
// - Each shift clock rising edge shifts data in at the LSB end.
// - On-time is spread over 128 segments of the counter period.
`timescale 1ns/10ps
`default_nettype none
module rlbpc_core (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Serial link pins
    input  wire logic        serial_shift_clock_in,
    input  wire logic        serial_data_in,
    // Constant-current sink outputs, high means sinking
    output var  logic [11:0] sink_output,
    // Group current scales
    output var  logic [6:0]  group_current_scale_red,
    output var  logic [6:0]  group_current_scale_green,
    output var  logic [6:0]  group_current_scale_blue,
    // Status
    output var  logic        outputs_blanked
);
    import rlbpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: first stage feeds only the second
    logic        sck_s1_r;
    logic        sck_s2_r;
    logic        sck_d_r;
    logic        sdi_s1_r;
    logic        sdi_s2_r;
    logic        sck_rise;
    logic        sck_fall;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_d_r  <= 1'b0;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= serial_shift_clock_in;
            sck_s2_r <= sck_s1_r;
            sck_d_r  <= sck_s2_r;
            sdi_s1_r <= serial_data_in;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    // Edge finders on the settled copy
    assign sck_rise = sck_s2_r & ~sck_d_r;
    assign sck_fall = ~sck_s2_r & sck_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Shift register, deliberately without reset
    logic [SHIFT_W-1:0] shift_r;

    always_ff @(posedge mclk) begin
        if (sck_rise) begin
            shift_r <= {shift_r[SHIFT_W-2:0], sdi_s2_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch sequencer: load after the link has gone quiet
    rlbpc_lstate_t            lstate_r;
    rlbpc_lstate_t            lstate_nxt;
    logic [IDLE_CNT_W-1:0]    idle_r;
    logic                     load;

    always_comb begin
        lstate_nxt = lstate_r;
        case (lstate_r)
            RLBPC_L_IDLE: begin
                if (sck_rise) begin
                    lstate_nxt = RLBPC_L_SHIFT;
                end
            end
            RLBPC_L_SHIFT: begin
                if (!sck_rise && idle_r == IDLE_CNT_W'(LATCH_IDLE_CYC - 1)) begin
                    lstate_nxt = RLBPC_L_LOAD;
                end
            end
            RLBPC_L_LOAD: begin
                lstate_nxt = sck_rise ? RLBPC_L_SHIFT : RLBPC_L_IDLE;
            end
            default: begin
                lstate_nxt = RLBPC_L_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lstate_r <= RLBPC_L_IDLE;
        end else begin
            lstate_r <= lstate_nxt;
        end
    end

    // Quiet-time counter restarts on every shift clock rising edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            idle_r <= '0;
        end else if (sck_rise || lstate_r != RLBPC_L_SHIFT) begin
            idle_r <= '0;
        end else begin
            idle_r <= idle_r + IDLE_CNT_W'(1);
        end
    end

    assign load = (lstate_r == RLBPC_L_LOAD);

    ////////////////////////////////////////////////////////////////////////
    // Control latch: data bits keep no reset value, output-off does
    logic [LATCH_W-1:0] latch_r;
    logic               blank_r;

    always_ff @(posedge mclk) begin
        if (load) begin
            latch_r <= shift_r[LATCH_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            blank_r <= BLANK_RESET;
        end else if (load) begin
            blank_r <= shift_r[BIT_BLANK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Group current scales
    // seven-bit scales
    // scale sets current
    // Current is analog: the pins carry scale, sink current is max*scale/127
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            group_current_scale_red   <= 7'h00;
            group_current_scale_green <= 7'h00;
            group_current_scale_blue  <= 7'h00;
        end else begin
            group_current_scale_red   <= latch_r[BC_LSB_RED +: BC_W];
            group_current_scale_green <= latch_r[BC_LSB_GRN +: BC_W];
            group_current_scale_blue  <= latch_r[BC_LSB_BLU +: BC_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared grayscale counter
    logic [15:0] gs_cnt_r;
    logic        count_edge_select;
    logic        external_ref_clock_select;
    logic        ref_tick;

    assign count_edge_select         = latch_r[BIT_EDGE_SEL];
    assign external_ref_clock_select = latch_r[BIT_EXT_CLOCK];

    // shift clock as reference
    // Internal reference is mclk itself, so edge choice has no effect there
    assign ref_tick = external_ref_clock_select
                    ? (count_edge_select ? sck_rise : sck_fall)
                    : 1'b1;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            gs_cnt_r <= 16'h0000;
        end else if (blank_r) begin
            gs_cnt_r <= 16'h0000;
        end else if (ref_tick) begin
            gs_cnt_r <= gs_cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segmented PWM comparator
    rlbpc_pwm_if pwm_bus ();

    assign pwm_bus.cnt = gs_cnt_r;

    always_comb begin
        for (int ch = 0; ch < N_CH; ch++) begin
            pwm_bus.gs[ch] = latch_r[ch*GS_W +: GS_W];
        end
    end

    rlbpc_espwm u_espwm (
        .p (pwm_bus.pwm)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sink_output <= 12'h000;
        end else if (blank_r) begin
            sink_output <= 12'h000;
        end else begin
            sink_output <= pwm_bus.on;
        end
    end

    // Status mirrors the output-off flag
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            outputs_blanked <= BLANK_RESET;
        end else begin
            outputs_blanked <= blank_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_blank_clears_cnt: assert property (
        @(posedge mclk) disable iff (!reset_n)
        blank_r |=> (gs_cnt_r == 16'h0000))
        else $error("counter not cleared while output-off");

    a_blank_holds_zero: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (blank_r && !load) [*3] |=> (gs_cnt_r == 16'h0000) && (sink_output == 12'h000))
        else $error("counter or outputs moved while output-off");

    a_int_count_step: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!blank_r && !external_ref_clock_select) |=> (gs_cnt_r == $past(gs_cnt_r) + 16'h0001))
        else $error("internal reference did not advance counter by one");

    a_ext_edge_only: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!blank_r && external_ref_clock_select && !sck_rise && !sck_fall) |=> $stable(gs_cnt_r))
        else $error("counter moved without a shift clock edge");

    // Case equality: the register starts undefined and fills from the LSB,
    // so the upper bits legitimately carry unknowns through the first frame
    a_shift_at_lsb: assert property (
        @(posedge mclk) disable iff (!reset_n)
        sck_rise |=> (shift_r[0] === $past(sdi_s2_r))
                     && (shift_r[SHIFT_W-1:1] === $past(shift_r[SHIFT_W-2:0])))
        else $error("shift register did not take data at LSB");

    a_scale_at_once: assert property (
        @(posedge mclk) disable iff (!reset_n)
        load |=> ##1 (group_current_scale_red == $past(shift_r[BC_LSB_RED +: BC_W], 2)))
        else $error("new scale not applied two cycles after load");

    a_zero_stays_off: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (latch_r[GS_W-1:0] == GS_ZERO && !load) |=> !sink_output[0])
        else $error("zero grayscale channel turned on");

    a_full_stays_on: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (latch_r[GS_W +: GS_W] == GS_MAX && !blank_r) |=> sink_output[1])
        else $error("full-scale channel turned off");

    a_spread_second: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (latch_r[3*GS_W +: GS_W] == 16'h0002 && !blank_r && gs_cnt_r == 16'h8000)
        |=> sink_output[3])
        else $error("second count of value two not in segment 64");

    // Forced off within one cycle of the flag, whatever the grayscale holds
    a_blank_forces_off: assert property (
        @(posedge mclk) disable iff (!reset_n)
        blank_r |=> (sink_output == 12'h000))
        else $error("outputs not forced off while output-off");

    // Status pin follows the flag one cycle behind
    a_status_mirror: assert property (
        @(posedge mclk) disable iff (!reset_n)
        1'b1 |=> (outputs_blanked == $past(blank_r)))
        else $error("output-off status does not follow the flag");

    // Green and blue take their own fields, not the red one
    a_scale_groups: assert property (
        @(posedge mclk) disable iff (!reset_n)
        load |=> ##1 (group_current_scale_green == $past(shift_r[BC_LSB_GRN +: BC_W], 2))
                     && (group_current_scale_blue == $past(shift_r[BC_LSB_BLU +: BC_W], 2)))
        else $error("green or blue scale not taken from its own field");

endmodule
`default_nettype wire

/* File: rlbpc_host_model.sv */
// Purpose: Host model driving the two-wire shift link of the core
// Assumes: Stepped from the bench clock, 800 ns per shift bit
// Notes:   Shift clock rests low between frames and data turns over
`timescale 1ns/10ps
`default_nettype none
module rlbpc_host_model (
    // Bench clock
    input  wire logic mclk,
    // Link pins
    output var  logic sck,
    output var  logic sdi
);
    // Quiet link at time zero
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Single clock level change, used for external counter steps
    task automatic set_sck(input logic v);
        @(posedge mclk);
        sck <= v;
    endtask

    // MSB first shifting
    // Data set two cycles ahead of the rise and held past the fall
    task automatic send(input logic [223:0] f);
        for (int i = 223; i >= 0; i--) begin
            @(posedge mclk);
            sdi <= f[i];
            repeat (2) @(posedge mclk);
            sck <= 1'b1;
            repeat (4) @(posedge mclk);
            sck <= 1'b0;
            @(posedge mclk);
        end
        @(posedge mclk);
        sdi <= ~f[0];   // Released line shows no stale bit
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the brightness and PWM core
// Assumes: 10 MHz core clock, host model shifting whole frames
// Notes:   One full counter period is watched, so the run is long
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rlbpc_pkg::*;

    logic              mclk;
    logic              reset_n;
    logic              sck;
    logic              sdi;
    logic [11:0]       sink;
    logic [6:0]        sc_r;
    logic [6:0]        sc_g;
    logic [6:0]        sc_b;
    logic              blanked;
    int                err_total;
    int                n_tests;
    logic [11:0][15:0] gs_tab;
    int                on_cnt [12];
    int                run;
    int                run_max;

    rlbpc_core dut (
        .mclk                      (mclk),
        .reset_n                   (reset_n),
        .serial_shift_clock_in     (sck),
        .serial_data_in            (sdi),
        .sink_output               (sink),
        .group_current_scale_red   (sc_r),
        .group_current_scale_green (sc_g),
        .group_current_scale_blue  (sc_b),
        .outputs_blanked           (blanked)
    );

    rlbpc_host_model host (
        .mclk (mclk),
        .sck  (sck),
        .sdi  (sdi)
    );

    // Core clock
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Frame builder, top six bits left zero
    function automatic logic [223:0] mk(input logic e, input logic x, input logic bl,
        input logic [6:0] r, input logic [6:0] g, input logic [6:0] b,
        input logic [11:0][15:0] gs);
        logic [223:0] f;
        f = '0;
        f[BIT_EDGE_SEL] = e;
        f[BIT_EXT_CLOCK] = x;
        f[BIT_BLANK] = bl;
        f[BC_LSB_BLU +: BC_W] = b;
        f[BC_LSB_GRN +: BC_W] = g;
        f[BC_LSB_RED +: BC_W] = r;
        f[191:0] = gs;
        return f;
    endfunction

    // Frame then quiet time long enough for the latch to load
    task automatic load(input logic [223:0] f);
        host.send(f);
        repeat (100) @(posedge mclk);
    endtask

    // Outputs must stay forced off for n cycles
    task automatic hold_off(input int n);
        repeat (n) begin
            @(negedge mclk);
            chk({blanked, sink}, {1'b1, 12'h000});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, above the expected 77k cycles of the whole run
    initial begin
        repeat (90000) @(posedge mclk);
        err_total++;
        final_report();
    end

    // Main sequence
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        err_total = 0;
        n_tests = 0;
        gs_tab = {16'h1234, 16'hFFFE, 16'h7FFF, 16'h1FFF, 16'h8000, 16'h0200,
                  16'h0005, 16'h0003, 16'h0002, 16'h0001, 16'hFFFF, 16'h0000};
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        hold_off(30);
        // Blank frame with full grayscale must stay dark
        load(mk(1'b1, 1'b0, 1'b1, 7'h7F, 7'h01, 7'h40, {12{16'hFFFF}}));
        chk({sc_r, sc_g, sc_b}, {7'h7F, 7'h01, 7'h40});
        hold_off(200);
        // External clock: counter moves only on shift clock edges
        for (int e = 0; e < 2; e++) begin
            load(mk(1'b1, 1'b0, 1'b1, 7'h00, 7'h00, 7'h00, {12{16'hFFFF}}));
            load(mk(e[0], 1'b1, 1'b0, 7'h7F, 7'h7F, 7'h7F, {{11{16'h0000}}, 16'h0001}));
            repeat (50) begin
                @(negedge mclk);
                chk(sink, 12'h001);
            end
            host.set_sck(1'b1);
            repeat (6) @(negedge mclk);
            chk(sink[0], e ? 32'h0 : 32'h1);
            host.set_sck(1'b0);
            repeat (6) @(negedge mclk);
            chk(sink[0], 32'h0);
        end
        // valid data loaded with the clear
        load(mk(1'b0, 1'b0, 1'b0, 7'h00, 7'h7F, 7'h55, gs_tab));
        chk({sc_r, sc_g, sc_b}, {7'h00, 7'h7F, 7'h55});
        chk(blanked, 32'h0);
        // One whole counter period, any phase gives the same totals
        run = 0;
        run_max = 0;
        for (int i = 0; i < 12; i++) on_cnt[i] = 0;
        repeat (65536) begin
            @(negedge mclk);
            for (int i = 0; i < 12; i++) on_cnt[i] += (sink[i] === 1'b1);
            run = (sink[6] === 1'b1) ? run + 1 : 0;
            if (run > run_max) run_max = run;
        end
        for (int i = 0; i < 12; i++) begin
            chk(on_cnt[i], (gs_tab[i] === GS_MAX) ? 32'h10000 : 32'(gs_tab[i]));
        end
        chk(run_max, 32'h4);
        final_report();
    end
endmodule
`default_nettype wire
